// [logic/spfe_erase_seq.sv]
`include "spfe_regs.svh"
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Page erase is 81h plus three address bytes; 1024 pages of 256 bytes.
// - Address byte one holds index bits 9:8, byte two 7:0, byte three ignored.
// - Chip select rise after page erase sets the page erased; busy meanwhile.
// - A location that fails to erase sets the erase error flag.
// - Block erase opcodes 20h, 52h, D8h take three address bytes.
// - Erase runs only with the write enable latch set, else discarded.
// - Block erase ignores address bits 11:0, 14:0 or 15:0 by size.
// - Block erase aborts on short address or unaligned chip select rise.
// - A protected target region is not erased; device returns idle.
// - Short address, unaligned release or protection clears the latch.
// - Busy during a good erase; latch cleared before erase completes.
// - After 16 clocks of 25h, output goes low as soon as busy ends.
// - Chip erase 60h or C7h, no address, erases whole array on release.
// - Chip erase is refused if any sector is protected.
// - Unaligned chip erase does not erase; latch cleared too.
// - 06h sets the write enable latch on chip select release.
// - Short or unaligned latch commands leave the latch unchanged.
// - 04h clears the write enable latch on chip select release.
module spfe_erase_seq
    import spfe_pkg::*;
#(
    parameter int NUM_PAGES = 1024,
    parameter int PAGE_AW = 10,
    parameter int NUM_SECTORS = 4,
    parameter int STEP_CYCLES = 4
) (
    // Clock and reset.
    input wire logic REF_CLK_I,
    input wire logic RESET_I,
    // Serial link pins.
    input wire logic CS_N_I,
    input wire logic SCK_I,
    input wire logic SI_I,
    output logic SO_O,
    output logic SO_OE_O,
    // Array environment.
    input wire logic [NUM_SECTORS-1:0] PROT_SECTOR_I,
    input wire logic ERASE_FAULT_I,
    input wire logic [PAGE_AW-1:0] QUERY_PAGE_I,
    output logic QUERY_ERASED_O,
    // Status.
    output logic BUSY_O,
    output logic WRITE_ENABLE_LATCH_O,
    output logic ERASE_PROGRAM_ERROR_FLAG_O
);

    localparam int SECT_W = (NUM_SECTORS > 1) ? $clog2(NUM_SECTORS) : 1;
    localparam int STEP_W = $clog2(STEP_CYCLES + 1);

    // =================================================================
    // Parameter checks.
    if (NUM_PAGES != (1 << PAGE_AW) || PAGE_AW != 10)
    begin : g_bad_pages
        $error("Page count must match the ten bit page index.");
    end
    if (NUM_SECTORS < 2 || (1 << SECT_W) != NUM_SECTORS
        || NUM_SECTORS > NUM_PAGES)
    begin : g_bad_sectors
        $error("Sector count must be a power of two within the pages.");
    end
    if (STEP_CYCLES < 1)
    begin : g_bad_step
        $error("Erase step must be at least one cycle.");
    end

    // =================================================================
    // State.
    typedef struct packed {
        logic cs_m, cs_s, cs_p;
        logic sck_m, sck_s, sck_p;
        logic si_m, si_s;
        logic [7:0] shift;
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [2:0] bit_cnt;
        logic [2:0] byte_cnt;
        logic irq_armed;
        spfe_state_t state;
        logic [PAGE_AW-1:0] page_cur;
        logic [PAGE_AW-1:0] page_end;
        logic [STEP_W-1:0] step;
        logic busy;
        logic wr_latch;
        logic err_flag;
        logic so;
        logic so_oe;
    } spfe_seq_t;

    spfe_seq_t q, d;

    spfe_mem_if #(.AW(PAGE_AW)) mem ();

    // Helper terms, also watched by the checks.
    logic sck_rise, cs_rise, aligned, prot_hit, start;
    logic [7:0] in_byte;
    logic [PAGE_AW-1:0] span, tgt_page;
    spfe_cmd_t cmd;

    // =================================================================
    // Decoding functions.
    function automatic spfe_cmd_t cmd_of(input logic [7:0] op);
        case (op)
            `SPFE_OP_PAGE_ERASE: cmd_of = CMD_PAGE;
            `SPFE_OP_BLK4_ERASE: cmd_of = CMD_BLK4;
            `SPFE_OP_BLK32_ERASE: cmd_of = CMD_BLK32;
            `SPFE_OP_BLK64_ERASE: cmd_of = CMD_BLK64;
            `SPFE_OP_CHIP_ERASE_A: cmd_of = CMD_CHIP;
            `SPFE_OP_CHIP_ERASE_B: cmd_of = CMD_CHIP;
            `SPFE_OP_LATCH_SET: cmd_of = CMD_LATCH_SET;
            `SPFE_OP_LATCH_CLR: cmd_of = CMD_LATCH_CLR;
            `SPFE_OP_STATUS_IRQ: cmd_of = CMD_STATUS_IRQ;
            default: cmd_of = CMD_NONE;
        endcase
    endfunction : cmd_of

    // Page mask of the region each erase covers.
    function automatic logic [PAGE_AW-1:0] span_of(input spfe_cmd_t c);
        case (c)
            CMD_BLK4: span_of = PAGE_AW'(`SPFE_SPAN_BLK4);
            CMD_BLK32: span_of = PAGE_AW'(`SPFE_SPAN_BLK32);
            CMD_BLK64: span_of = PAGE_AW'(`SPFE_SPAN_BLK64);
            CMD_CHIP: span_of = PAGE_AW'(`SPFE_SPAN_CHIP);
            default: span_of = PAGE_AW'(`SPFE_SPAN_PAGE);
        endcase
    endfunction : span_of

    function automatic logic is_erase(input spfe_cmd_t c);
        is_erase = (c == CMD_PAGE) || (c == CMD_BLK4) || (c == CMD_BLK32)
            || (c == CMD_BLK64) || (c == CMD_CHIP);
    endfunction : is_erase

    // =================================================================
    // Frame decode terms.
    always_comb
    begin
        sck_rise = q.sck_s & ~q.sck_p & ~q.cs_s;
        cs_rise = q.cs_s & ~q.cs_p;
        in_byte = {q.shift[6:0], q.si_s};
        aligned = (q.bit_cnt == 3'h0);
        cmd = cmd_of(q.opcode);
        span = span_of(cmd);
        // Byte one low bits then byte two: index bits 9:8 and 7:0.
        tgt_page = q.addr[`SPFE_PAGE_LSB +: PAGE_AW] & ~span;
        prot_hit = (cmd == CMD_CHIP) ? |PROT_SECTOR_I
            : PROT_SECTOR_I[tgt_page[PAGE_AW-1 -: SECT_W]];
        start = cs_rise && !q.busy && is_erase(cmd) && q.wr_latch && aligned
            && !prot_hit
            && (q.byte_cnt == ((cmd == CMD_CHIP) ? `SPFE_OPCODE_BYTES
                : `SPFE_FRAME_BYTES) || cmd == CMD_CHIP);
    end

    // =================================================================
    // Next state.
    always_comb
    begin
        d = q;
        mem.we = 1'b0;
        mem.addr = QUERY_PAGE_I;
        d.cs_m = CS_N_I;
        d.cs_s = q.cs_m;
        d.cs_p = q.cs_s;
        d.sck_m = SCK_I;
        d.sck_s = q.sck_m;
        d.sck_p = q.sck_s;
        d.si_m = SI_I;
        d.si_s = q.si_m;

        // Shift one bit per rising clock; bytes past the address drop.
        if (sck_rise)
        begin
            d.shift = in_byte;
            d.bit_cnt = q.bit_cnt + 3'h1;
            if (q.bit_cnt == `SPFE_LAST_BIT
                && q.byte_cnt != `SPFE_FRAME_BYTES)
            begin
                d.byte_cnt = q.byte_cnt + 3'h1;
                if (q.byte_cnt == 3'h0)
                begin
                    d.opcode = in_byte;
                end
                else
                begin
                    d.addr = {q.addr[15:0], in_byte};
                end
                if (q.byte_cnt == `SPFE_IRQ_BYTES - 3'h1
                    && cmd == CMD_STATUS_IRQ)
                begin
                    d.irq_armed = 1'b1;
                end
            end
        end

        // Act on the release of chip select.
        if (cs_rise)
        begin
            d.bit_cnt = 3'h0;
            d.byte_cnt = 3'h0;
            d.opcode = 8'h00;
            d.irq_armed = 1'b0;
            if (!q.busy)
            begin
                case (cmd)
                    CMD_LATCH_SET:
                    begin
                        if (aligned && q.byte_cnt != 3'h0)
                        begin
                            d.wr_latch = 1'b1;
                        end
                    end
                    CMD_LATCH_CLR:
                    begin
                        if (aligned && q.byte_cnt != 3'h0)
                        begin
                            d.wr_latch = 1'b0;
                        end
                    end
                    CMD_PAGE, CMD_BLK4, CMD_BLK32, CMD_BLK64, CMD_CHIP:
                    begin
                        if (start)
                        begin
                            d.state = ST_ERASE;
                            d.busy = 1'b1;
                            d.wr_latch = 1'b0;
                            d.err_flag = 1'b0;
                            d.page_cur = tgt_page;
                            d.page_end = tgt_page | span;
                            d.step = '0;
                        end
                        else if (q.wr_latch)
                        begin
                            // A refused erase with the latch set clears the latch.
                            d.wr_latch = 1'b0;
                        end
                    end
                    default:
                    begin
                        d.wr_latch = q.wr_latch;
                    end
                endcase
            end
        end

        // Walk the target pages, one per erase step.
        case (q.state)
            ST_ERASE:
            begin
                d.step = q.step + STEP_W'(1);
                if (q.step == STEP_W'(STEP_CYCLES - 1))
                begin
                    d.step = '0;
                    mem.we = 1'b1;
                    mem.addr = q.page_cur;
                    if (ERASE_FAULT_I)
                    begin
                        d.err_flag = 1'b1;
                    end
                    if (q.page_cur == q.page_end)
                    begin
                        d.state = ST_IDLE;
                        d.busy = 1'b0;
                    end
                    else
                    begin
                        d.page_cur = q.page_cur + PAGE_AW'(1);
                    end
                end
            end
            default:
            begin
                d.step = '0;
            end
        endcase

        // Drive the output high while busy, low once it ends.
        d.so_oe = d.irq_armed & ~q.cs_s;
        d.so = d.so_oe & d.busy;
    end

    // =================================================================
    // Registers.
    always_ff @(posedge REF_CLK_I)
    begin
        if (RESET_I)
        begin
            q <= '0;
            q.cs_m <= 1'b1;
            q.cs_s <= 1'b1;
            q.cs_p <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    spfe_page_map #(
        .NUM_PAGES(NUM_PAGES),
        .AW(PAGE_AW)
    ) u_map (
        .clk_i(REF_CLK_I),
        .rst_i(RESET_I),
        .port(mem.mem)
    );

    // Outputs straight from flip-flops.
    assign SO_O = q.so;
    assign SO_OE_O = q.so_oe;
    assign BUSY_O = q.busy;
    assign WRITE_ENABLE_LATCH_O = q.wr_latch;
    assign ERASE_PROGRAM_ERROR_FLAG_O = q.err_flag;
    assign QUERY_ERASED_O = mem.rdata;

    // =================================================================
    // Checks.
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (RESET_I);

    sequence seq_page_start;
        start && cmd == CMD_PAGE;
    endsequence

    sequence seq_busy_then_free;
        BUSY_O && !WRITE_ENABLE_LATCH_O ##[1:1000] !BUSY_O;
    endsequence

    chk_page_busy_done: assert property (
        seq_page_start |=> seq_busy_then_free)
        else $error("Page erase busy window wrong.");

    chk_latch_set: assert property (
        cs_rise && !q.busy && cmd == CMD_LATCH_SET && aligned
        && q.byte_cnt != 3'h0 |=> WRITE_ENABLE_LATCH_O)
        else $error("Latch set command did not set latch.");

    chk_latch_clr: assert property (
        cs_rise && !q.busy && cmd == CMD_LATCH_CLR && aligned
        && q.byte_cnt != 3'h0 |=> !WRITE_ENABLE_LATCH_O)
        else $error("Latch clear command did not clear latch.");

    chk_latch_abort: assert property (
        cs_rise && (cmd == CMD_LATCH_SET || cmd == CMD_LATCH_CLR)
        && !aligned |=> $stable(WRITE_ENABLE_LATCH_O))
        else $error("Aborted latch command changed latch.");

    chk_no_latch: assert property (
        cs_rise && !q.busy && is_erase(cmd) && !q.wr_latch
        |=> !BUSY_O && !WRITE_ENABLE_LATCH_O)
        else $error("Erase ran without write enable.");

    chk_blk_abort: assert property (
        cs_rise && !q.busy && q.wr_latch && cmd == CMD_BLK4
        && (q.byte_cnt != `SPFE_FRAME_BYTES || !aligned || prot_hit)
        |=> !BUSY_O && !WRITE_ENABLE_LATCH_O)
        else $error("Block erase abort handled wrongly.");

    chk_chip_prot: assert property (
        cs_rise && !q.busy && q.wr_latch && cmd == CMD_CHIP && prot_hit
        |=> !BUSY_O && !WRITE_ENABLE_LATCH_O)
        else $error("Protected chip erase was not refused.");

    chk_blk64_span: assert property (
        start && cmd == CMD_BLK64
        |=> q.page_cur[7:0] == 8'h00 && q.page_end[7:0] == 8'hff)
        else $error("64K block region misaligned.");

    chk_chip_span: assert property (
        start && cmd == CMD_CHIP
        |=> q.page_cur == '0 && q.page_end == '1)
        else $error("Chip erase does not cover the array.");

    chk_fault_flag: assert property (
        mem.we && ERASE_FAULT_I
        |=> ERASE_PROGRAM_ERROR_FLAG_O ##1 ERASE_PROGRAM_ERROR_FLAG_O)
        else $error("Erase failure not flagged.");

    chk_irq_level: assert property (
        SO_OE_O |-> SO_O == BUSY_O)
        else $error("Status output does not follow busy.");

endmodule : spfe_erase_seq

`default_nettype wire

// [logic/spfe_regs.svh]
`ifndef SPFE_REGS_SVH
`define SPFE_REGS_SVH

// =====================================================================
// Command opcodes.
`define SPFE_OP_PAGE_ERASE 8'h81
`define SPFE_OP_BLK4_ERASE 8'h20
`define SPFE_OP_BLK32_ERASE 8'h52
`define SPFE_OP_BLK64_ERASE 8'hd8
`define SPFE_OP_CHIP_ERASE_A 8'h60
`define SPFE_OP_CHIP_ERASE_B 8'hc7
`define SPFE_OP_LATCH_SET 8'h06
`define SPFE_OP_LATCH_CLR 8'h04
`define SPFE_OP_STATUS_IRQ 8'h25

// =====================================================================
// Frame layout in bytes, opcode byte included.
`define SPFE_OPCODE_BYTES 3'h1
`define SPFE_FRAME_BYTES 3'h4
`define SPFE_IRQ_BYTES 3'h2
`define SPFE_LAST_BIT 3'h7

// =====================================================================
// Address fields and erase spans as page masks.
`define SPFE_PAGE_LSB 8
`define SPFE_SPAN_PAGE 10'h000
`define SPFE_SPAN_BLK4 10'h00f
`define SPFE_SPAN_BLK32 10'h07f
`define SPFE_SPAN_BLK64 10'h0ff
`define SPFE_SPAN_CHIP 10'h3ff

`endif

// [logic/spfe_pkg.sv]
package spfe_pkg;

    // =================================================================
    // Decoded command classes.
    typedef enum logic [3:0] {
        CMD_NONE,
        CMD_LATCH_SET,
        CMD_LATCH_CLR,
        CMD_PAGE,
        CMD_BLK4,
        CMD_BLK32,
        CMD_BLK64,
        CMD_CHIP,
        CMD_STATUS_IRQ
    } spfe_cmd_t;

    // Sequencer states.
    typedef enum logic {
        ST_IDLE,
        ST_ERASE
    } spfe_state_t;

endpackage : spfe_pkg

// [logic/spfe_mem_if.sv]
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Port between the sequencer and the page state memory.
interface spfe_mem_if #(parameter int AW = 10);
    logic we;
    logic [AW-1:0] addr;
    logic rdata;

    modport ctrl (output we, output addr, input rdata);
    modport mem (input we, input addr, output rdata);
endinterface : spfe_mem_if

`default_nettype wire

// [logic/spfe_page_map.sv]
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// One erased flag per page; read data comes out of a register.
module spfe_page_map #(
    parameter int NUM_PAGES = 1024,
    parameter int AW = 10
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Sequencer side.
    spfe_mem_if.mem port
);

    typedef struct packed {
        logic [NUM_PAGES-1:0] erased;
        logic rdata;
    } spfe_map_t;

    spfe_map_t q, d;

    // Writing marks the page erased, all bits at one.
    always_comb
    begin
        d = q;
        if (port.we)
        begin
            d.erased[port.addr] = 1'b1;
        end
        d.rdata = q.erased[port.addr];
    end

    // Pages start as not erased after reset.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign port.rdata = q.rdata;

endmodule : spfe_page_map

`default_nettype wire

// [dv/spfe_host.sv]
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Host controller model: frames commands in SPI mode 0.
module spfe_host (
    // Serial link toward the device.
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o
);
    realtime half_ns = 62.5;

    // Deselected at start with the clock parked low.
    initial
    begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end

    // Shifts the leading bits of data out, most significant first.
    task automatic frame(input logic [39:0] data, input int nbits,
                         input bit hold);
        cs_n_o = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            si_o = data[39-i];
            #(half_ns);
            sck_o = 1'b1;
            #(half_ns);
            sck_o = 1'b0;
        end
        si_o = ~si_o;
        if (!hold)
            finish_frame();
    endtask : frame

    // Releases the device; the data line goes back to showing the last bit.
    task automatic finish_frame;
        #(half_ns);
        cs_n_o = 1'b1;
        si_o = ~si_o;
        #40;
    endtask : finish_frame
endmodule : spfe_host

`default_nettype wire

// [dv/spfe_erase_seq_bench.sv]
`timescale 1ns/1ps
`default_nettype none

`define SPFE_CMP(what, exp, got) \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
        $display("unexpected %s: expected %b, seen %b", what, exp, got); \
        fail_count++; \
    end

// =====================================================================
// Self-checking bench for the erase and latch sequencer.
module spfe_erase_seq_bench;
    typedef struct {int sel; logic exp;} spfe_note_t;
    localparam int STEP = 16;
    logic ref_clk = 1'b0;
    logic reset;
    wire logic cs_n, sck, si;
    logic so, so_oe, busy, wr_latch, err_flag, qerased, fault;
    logic [3:0] prot;
    logic [9:0] qpage;
    logic [5:0] outs;
    int fail_count = 0;
    int checks_done = 0;
    int seed;
    spfe_note_t notes[$];
    spfe_note_t nt;
    string names [6] = '{"latch", "busy", "error", "erased", "so", "so_oe"};
    logic [7:0] ops [3] = '{8'h20, 8'h52, 8'hd8};
    logic [9:0] bases [3] = '{10'h010, 10'h080, 10'h100};
    logic [9:0] spans [3] = '{10'h00f, 10'h07f, 10'h0ff};

    // The clock and the watched outputs.
    always #5 ref_clk = ~ref_clk;
    assign outs = {so_oe, so, qerased, err_flag, busy, wr_latch};

    spfe_host host (.cs_n_o(cs_n), .sck_o(sck), .si_o(si));

    spfe_erase_seq #(.STEP_CYCLES(STEP)) uut (
        .REF_CLK_I(ref_clk), .RESET_I(reset), .CS_N_I(cs_n),
        .SCK_I(sck), .SI_I(si), .SO_O(so), .SO_OE_O(so_oe),
        .PROT_SECTOR_I(prot), .ERASE_FAULT_I(fault),
        .QUERY_PAGE_I(qpage), .QUERY_ERASED_O(qerased),
        .BUSY_O(busy), .WRITE_ENABLE_LATCH_O(wr_latch),
        .ERASE_PROGRAM_ERROR_FLAG_O(err_flag));

    // Each noted expectation is compared with the settled outputs.
    always @(negedge ref_clk)
    begin
        #1;
        while (notes.size() > 0)
        begin
            nt = notes.pop_front();
            `SPFE_CMP(names[nt.sel], nt.exp, outs[nt.sel])
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    task automatic note(input int sel, input logic exp);
        notes.push_back('{sel, exp});
    endtask : note

    task automatic stat(input logic w, input logic b);
        note(0, w);
        note(1, b);
    endtask : stat

    task automatic send(input logic [39:0] d, input int n);
        host.frame(d, n, 1'b0);
        cyc(7);
    endtask : send

    task automatic set_latch;
        send({8'h06, 32'h0}, 8);
    endtask : set_latch

    // Opcode, random index filler, page index, random filler bytes.
    task automatic blk(input logic [7:0] op, input logic [9:0] pg,
                       input int nb);
        logic [7:0] r;
        r = 8'($random(seed));
        send({op, r[5:0], pg, r, ~r}, nb);
    endtask : blk

    task automatic query(input logic [9:0] p, input logic e);
        qpage = p;
        cyc(2);
        note(3, e);
    endtask : query

    // Polls busy rather than sitting out a worst-case time.
    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 20000)
        begin
            cyc(1);
            n++;
        end
        `SPFE_CMP("idle wait", 1'b0, busy)
    endtask : wait_idle

    task automatic done_test(input string s);
        cyc(2);
        $display("test %s finished", s);
    endtask : done_test

    task automatic conclude;
        cyc(2);
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    // Gives up if the sequence hangs.
    initial
    begin
        #800us;
        fail_count++;
        conclude();
    end

    // Main sequence, inputs changed at the falling edge.
    initial
    begin
        seed = 32'h5641;
        reset = 1'b1;
        prot = 4'h0;
        fault = 1'b0;
        qpage = 10'h000;
        cyc(10);
        reset = 1'b0;
        cyc(3);
        stat(1'b0, 1'b0);
        note(2, 1'b0);
        note(5, 1'b0);
        query(10'h000, 1'b0);
        done_test("reset");
        send({8'h06, 32'h0}, 7);
        stat(1'b0, 1'b0);
        send({8'h06, 32'h5a}, 16);
        stat(1'b1, 1'b0);
        send({8'h04, 32'h0}, 9);
        stat(1'b1, 1'b0);
        send({8'h04, 32'hff}, 16);
        stat(1'b0, 1'b0);
        done_test("latch");
        blk(8'h81, 10'h2a5, 32);
        stat(1'b0, 1'b0);
        query(10'h2a5, 1'b0);
        set_latch();
        blk(8'h81, 10'h2a5, 32);
        stat(1'b0, 1'b1);
        wait_idle();
        query(10'h2a5, 1'b1);
        query(10'h2a4, 1'b0);
        query(10'h2a6, 1'b0);
        done_test("page");
        for (int k = 0; k < 3; k++)
        begin
            set_latch();
            fault = (k == 1);
            blk(ops[k], bases[k] | (10'($random(seed)) & spans[k]), 40);
            stat(1'b0, 1'b1);
            wait_idle();
            note(2, k == 1);
            fault = 1'b0;
            query(bases[k], 1'b1);
            query(bases[k] | spans[k], 1'b1);
            query((bases[k] | spans[k]) + 10'h001, 1'b0);
        end
        done_test("block");
        set_latch();
        blk(8'h20, 10'h040, 24);
        stat(1'b0, 1'b0);
        set_latch();
        blk(8'h52, 10'h040, 33);
        stat(1'b0, 1'b0);
        query(10'h040, 1'b0);
        prot = 4'h8;
        set_latch();
        blk(8'hd8, 10'h3c0, 40);
        stat(1'b0, 1'b0);
        query(10'h3c0, 1'b0);
        set_latch();
        send({8'hc7, 32'h0}, 8);
        stat(1'b0, 1'b0);
        prot = 4'h0;
        set_latch();
        send({8'h60, 32'h0}, 12);
        stat(1'b0, 1'b0);
        query(10'h3ff, 1'b0);
        done_test("abort");
        set_latch();
        send({8'h60, 32'hffffffff}, 40);
        stat(1'b0, 1'b1);
        wait_idle();
        query(10'h3ff, 1'b1);
        query(10'h200, 1'b1);
        set_latch();
        send({8'hc7, 32'h0}, 8);
        stat(1'b0, 1'b1);
        host.frame({8'h25, 32'h0}, 16, 1'b1);
        cyc(3);
        note(5, 1'b1);
        note(4, 1'b1);
        wait_idle();
        note(4, 1'b0);
        note(5, 1'b1);
        host.finish_frame();
        cyc(7);
        note(5, 1'b0);
        query(10'h155, 1'b1);
        done_test("chip");
        conclude();
    end
endmodule : spfe_erase_seq_bench

`default_nettype wire
